// ==== rtl/smci_regs.svh ====
/*
  Constants of the serial motor control interface: frame layout, register
  bit positions, bus offsets and timing counts in serial or core clock cycles.
  Assumes inclusion by bare name from the rtl/ folder.
*/
`ifndef SMCI_REGS_SVH
`define SMCI_REGS_SVH

// ****************************************************
// serial frame
// ****************************************************
`define SMCI_FRAME_BITS 5'h10
`define SMCI_LAST_BIT 5'h0F
`define SMCI_SEL_BIT 0

// ****************************************************
// motion/converter register fields
// ****************************************************
`define SMCI_MOT_REPORT 15
`define SMCI_MOT_ADC_START 14
`define SMCI_MOT_BRIDGE_A_DIR 11
`define SMCI_MOT_PHASE_A_DIR 10
`define SMCI_MOT_PHASE_B_DIR 9
`define SMCI_MOT_LS1_ON 8
`define SMCI_MOT_LS2_ON 7

// ****************************************************
// configuration register fields
// ****************************************************
`define SMCI_CFG_PHASE_A_DC 15
`define SMCI_CFG_PHASE_B_LS 14
`define SMCI_CFG_ADC_SLOW 13
`define SMCI_CFG_FILT_LONG 12

// ****************************************************
// timing in serial clock rising edges; latch wait in core clock cycles
// ****************************************************
`define SMCI_ACQ_FAST 7'h10
`define SMCI_ACQ_SLOW 7'h20
`define SMCI_CONV_FAST 7'h30
`define SMCI_CONV_SLOW 7'h60
`define SMCI_FILT_SHORT 3'h4
`define SMCI_FILT_LONG 3'h7
`define SMCI_RST_LAST 8'h7F
`define SMCI_LATCH_WAIT 2'h3

// ****************************************************
// bus word addresses, interrupt bits, core voltage codes
// ****************************************************
`define SMCI_ADDR_STATUS 3'h0
`define SMCI_ADDR_MASK 3'h1
`define SMCI_ADDR_MOTION 3'h2
`define SMCI_ADDR_CONFIG 3'h3
`define SMCI_ADDR_INFO 3'h4
`define SMCI_IRQ_FRAME 0
`define SMCI_IRQ_ADC 1
`define SMCI_IRQ_FAULT 2
`define SMCI_VCORE_1V5 2'h0
`define SMCI_VCORE_1V8 2'h1
`define SMCI_VCORE_2V5 2'h2

`endif

// ==== rtl/smci_pkg.sv ====
/*
  Types of the serial motor control interface: converter states and the
  state records of each module.
  Assumes smci_regs.svh constants for field meanings.
*/
package smci_pkg;

  typedef enum logic [1:0] {
    ADC_IDLE = 2'h0,
    ADC_ACQ = 2'h1,
    ADC_CONV = 2'h3
  } smci_adc_state_type;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic sclkLast;
    logic sclkRise;
    logic ceN;
    logic mosi;
  } smci_sync_state_type;

  typedef struct packed {
    logic level;
    logic [2:0] cnt;
  } smci_filt_state_type;

  typedef struct packed {
    logic [15:0] inShift;
    logic [15:0] outShift;
    logic [4:0] bitCnt;
    logic [15:0] motionReg;
    logic [15:0] cfgReg;
    smci_adc_state_type adcState;
    logic [6:0] adcCnt;
    logic [11:0] adcMeta;
    logic [11:0] adcRaw;
    logic [11:0] adcWord;
    logic adcHold;
    logic [9:0] pinMeta;
    logic [9:0] pinSync;
    logic [1:0] coreSel;
    logic coreLatched;
    logic [1:0] latchWait;
    logic [7:0] rstCnt;
    logic resetOutN;
    logic miso;
    logic misoOeN;
    logic [1:0] stepA;
    logic [1:0] stepB;
    logic bridgeA;
    logic bridgeB;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    logic irq;
    logic faultLast;
    logic waitreq;
    logic [31:0] readdata;
  } smci_core_state_type;

endpackage : smci_pkg

// ==== rtl/smci_link_if.sv ====
/*
  Carrier between the core, the pin synchroniser and the encoder filters.
  Assumes all signals live in the core_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface smci_link_if;
  logic sclkRise;
  logic ceN;
  logic mosi;
  logic filterLong;

  modport src (output sclkRise, output ceN, output mosi);
  modport core (input sclkRise, input ceN, input mosi, output filterLong);
  modport filt (input sclkRise, input filterLong);
endinterface : smci_link_if

`default_nettype wire

// ==== rtl/smci_sync.sv ====
/*
  Synchroniser for the serial clock, chip enable and data in pins, with
  rising-edge detection of the serial clock.
  Assumes core_clk runs well above twice the serial clock rate.
*/
`timescale 1ns/1ps
`default_nettype none

module smci_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // raw pins
  input wire logic sclk,
  input wire logic ceN,
  input wire logic mosi,
  // synchronised link
  smci_link_if.src link
);

  smci_pkg::smci_sync_state_type s;
  smci_pkg::smci_sync_state_type next_s;

  always_comb begin
    next_s = s;
    next_s.meta = {sclk, ceN, mosi};
    next_s.sync = s.meta;
    next_s.sclkLast = s.sync[2];
    // ce and data delayed one stage so they line up with the edge pulse
    next_s.sclkRise = s.sync[2] & ~s.sclkLast;
    next_s.ceN = s.sync[1];
    next_s.mosi = s.sync[0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.meta <= 3'h2;
      s.sync <= 3'h2;
      s.ceN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.sclkRise = s.sclkRise;
  assign link.ceN = s.ceN;
  assign link.mosi = s.mosi;

endmodule : smci_sync

`default_nettype wire

// ==== rtl/smci_filter.sv ====
/*
  Encoder comparator filter: output follows the input only after it has
  stayed at the new level for a number of serial clock rising edges.
  Assumes rawIn is already synchronised to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smci_regs.svh"

module smci_filter (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // timing and setting
  smci_link_if.filt link,
  // level
  input wire logic rawIn,
  output logic filtered
);

  smci_pkg::smci_filt_state_type s;
  smci_pkg::smci_filt_state_type next_s;
  logic [2:0] lim;

  // edge count lands the switch 3-4 or 6-7 serial periods after a change
  assign lim = link.filterLong ? `SMCI_FILT_LONG : `SMCI_FILT_SHORT;

  always_comb begin
    next_s = s;
    if (rawIn == s.level) begin
      next_s.cnt = 3'h0;
    end else if (link.sclkRise) begin
      if (s.cnt == lim - 3'h1) begin // [R4]
        next_s.level = rawIn;
        next_s.cnt = 3'h0;
      end else begin
        next_s.cnt = s.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign filtered = s.level;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_filt_switch;
    (s.level != $past(s.level)) |-> ($past(s.cnt) == $past(lim) - 3'h1);
  endproperty
  a_filt_switch: assert property (p_filt_switch) // [R4]
    else $error("filter switched before its edge count");

  property p_filt_hold;
    (rawIn == s.level) |=> (s.cnt == 3'h0) && $stable(s.level);
  endproperty
  a_filt_hold: assert property (p_filt_hold) // [R4]
    else $error("filter moved while input matched output");

endmodule : smci_filter

`default_nettype wire

// ==== rtl/smci_core.sv ====
/*
  Serial control interface core of a motor driver and supply device:
  16-bit write frames into motion and configuration registers, read frames
  of converter or status data, converter and reset timing from the serial
  clock, output stage steering, and an Avalon-MM register slave.
  Assumes the host runs the serial clock continuously; pins are async.
*/
// What this block does
// [R1] Host keeps the serial clock running freely, up to 16 MHz.
// [R2] Converter and reset timer advance only on serial clock edges.
// [R3] Commands enter on clock, enable and data in; replies leave on data out.
// [R4] Encoder filter needs 3-4 stable cycles, or 6-7 with its bit set.
// [R5] Acquisition lasts 15-16 clock periods, or 31-32 when slow.
// [R6] Conversion takes 48 or 96 periods; result goes out next frame.
// [R7] Two writable registers: motion/converter control and configuration.
// [R8] Two readable words: converter plus encoder, and status.
// [R9] Core voltage select is caught once after power-on, then ignored.
// [R10] Caught select picks 1.5, 1.8 or 2.5 volt core setting.
// [R11] Phase-A low sides act as stepper or DC bridge, gated by PWM.
// [R12] Stepper phase-B low sides follow the phase-B PWM pin.
// [R13] Phase-B direction and low-side switch states come from register bits.
// [R14] Bridge A follows its PWM pin with direction from a register bit.
// [R15] Frames are 16 bits MSB first; update lands on the 16th edge.
// [R16] Last bit high loads configuration, low loads motion register.
// [R17] Each edge with enable high preloads output; bit 15 shows first.
// [R18] Host ignores data out beyond 16 bits in one frame.
`timescale 1ns/1ps
`default_nettype none
`include "smci_regs.svh"

module smci_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  // serial link pins
  input wire logic sclk,
  input wire logic ceN,
  input wire logic mosi,
  output logic miso,
  output logic misoOeN,
  // pwm and sensing pins
  input wire logic phaseAPwmInput,
  input wire logic phaseBPwmInput,
  input wire logic bridgeAPwmInput,
  input wire logic encoderA,
  input wire logic encoderB,
  input wire logic underVoltage,
  input wire logic overTemp,
  input wire logic powerGood,
  input wire logic [1:0] coreVoltageSelectPin,
  // converter
  input wire logic [11:0] adcResult,
  output logic adcSampleHold,
  // output stages and supplies
  output logic [1:0] stepPhaseAOutput,
  output logic [1:0] stepPhaseBOutput,
  output logic bridgeAOutputA,
  output logic bridgeAOutputB,
  output logic [1:0] coreVoltageSetting,
  output logic resetOutN
);

  smci_pkg::smci_core_state_type s;
  smci_pkg::smci_core_state_type next_s;
  smci_link_if link ();
  logic encAFilt;
  logic encBFilt;
  logic [15:0] normalWord;
  logic [15:0] statusWord;
  logic [6:0] acqLen;
  logic [6:0] convLen;

  // ****************************************************
  // pin synchroniser and encoder filters
  // ****************************************************
  smci_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .sclk(sclk),
    .ceN(ceN),
    .mosi(mosi),
    .link(link)
  );

  smci_filter u_filt_a (
    .core_clk(core_clk),
    .rst(rst),
    .link(link),
    .rawIn(s.pinSync[3]),
    .filtered(encAFilt)
  );

  smci_filter u_filt_b (
    .core_clk(core_clk),
    .rst(rst),
    .link(link),
    .rawIn(s.pinSync[4]),
    .filtered(encBFilt)
  );

  assign link.filterLong = s.cfgReg[`SMCI_CFG_FILT_LONG]; // [R4]

  // ****************************************************
  // read words and converter lengths
  // ****************************************************
  assign normalWord = {encAFilt, encBFilt, 2'h0, s.adcWord}; // [R8]
  assign statusWord = {s.pinSync[5], s.pinSync[6], s.resetOutN,
                       s.adcState != smci_pkg::ADC_IDLE, encAFilt,
                       encBFilt, 8'h00, s.coreSel}; // [R8]
  assign acqLen = s.cfgReg[`SMCI_CFG_ADC_SLOW] ? `SMCI_ACQ_SLOW
                                                : `SMCI_ACQ_FAST;
  assign convLen = s.cfgReg[`SMCI_CFG_ADC_SLOW] ? `SMCI_CONV_SLOW
                                                 : `SMCI_CONV_FAST;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic [15:0] frameWord;
    logic frameLoad;
    logic adcDone;
    logic faultNow;
    logic [2:0] clr;
    logic [31:0] rdMux;
    logic pwmA;
    logic pwmB;
    logic pwmBr;
    frameWord = {s.inShift[14:0], link.mosi};
    faultNow = s.pinSync[5] | s.pinSync[6];
    frameLoad = 1'b0;
    adcDone = 1'b0;
    clr = 3'h0;
    rdMux = 32'h0000_0000;
    pwmA = s.pinSync[0];
    pwmB = s.pinSync[1];
    pwmBr = s.pinSync[2];
    next_s = s;
    next_s.pinMeta = {coreVoltageSelectPin, powerGood, overTemp,
                      underVoltage, encoderB, encoderA, bridgeAPwmInput,
                      phaseBPwmInput, phaseAPwmInput};
    next_s.pinSync = s.pinMeta;
    // result is held steady by the converter through conversion
    next_s.adcMeta = adcResult;
    next_s.adcRaw = s.adcMeta;

    // serial frames
    if (link.ceN) begin
      next_s.bitCnt = 5'h00;
      if (link.sclkRise) begin
        next_s.outShift = s.motionReg[`SMCI_MOT_REPORT] ? statusWord
                                                         : normalWord; // [R17]
      end
    end else if (link.sclkRise) begin
      next_s.outShift = {s.outShift[14:0], 1'b0}; // [R3]
      next_s.inShift = frameWord; // [R15]
      if (s.bitCnt != `SMCI_FRAME_BITS) begin
        next_s.bitCnt = s.bitCnt + 5'h01;
      end
      if (s.bitCnt == `SMCI_LAST_BIT) begin // [R15]
        frameLoad = 1'b1;
        if (frameWord[`SMCI_SEL_BIT]) begin // [R16]
          next_s.cfgReg = frameWord; // [R7]
        end else begin
          next_s.motionReg = frameWord; // [R7]
        end
      end
    end
    next_s.miso = next_s.outShift[15]; // [R3]
    next_s.misoOeN = 1'b0;

    // converter sequencing on serial clock edges
    case (s.adcState)
      smci_pkg::ADC_IDLE: begin
        if (frameLoad && !frameWord[`SMCI_SEL_BIT] &&
            frameWord[`SMCI_MOT_ADC_START]) begin
          next_s.adcState = smci_pkg::ADC_ACQ;
          next_s.adcCnt = 7'h00;
        end
      end
      smci_pkg::ADC_ACQ: begin
        if (link.sclkRise) begin // [R2]
          if (s.adcCnt == acqLen - 7'h01) begin // [R5]
            next_s.adcState = smci_pkg::ADC_CONV;
            next_s.adcCnt = 7'h00;
          end else begin
            next_s.adcCnt = s.adcCnt + 7'h01;
          end
        end
      end
      smci_pkg::ADC_CONV: begin
        if (link.sclkRise) begin
          if (s.adcCnt == convLen - 7'h01) begin // [R6]
            next_s.adcState = smci_pkg::ADC_IDLE;
            next_s.adcWord = s.adcRaw;
            adcDone = 1'b1;
          end else begin
            next_s.adcCnt = s.adcCnt + 7'h01;
          end
        end
      end
      default: begin
        next_s.adcState = smci_pkg::ADC_IDLE;
      end
    endcase
    next_s.adcHold = (next_s.adcState == smci_pkg::ADC_ACQ);

    // reset timer counts serial edges once supplies are good
    if (!s.pinSync[7]) begin
      next_s.rstCnt = 8'h00;
      next_s.resetOutN = 1'b0;
    end else if (link.sclkRise && !s.resetOutN) begin // [R2]
      if (s.rstCnt == `SMCI_RST_LAST) begin
        next_s.resetOutN = 1'b1;
      end else begin
        next_s.rstCnt = s.rstCnt + 8'h01;
      end
    end

    // core voltage caught once, after the synchroniser has filled
    if (!s.coreLatched) begin
      if (s.latchWait == `SMCI_LATCH_WAIT) begin // [R9]
        next_s.coreLatched = 1'b1;
        case (s.pinSync[9:8]) // [R10]
          2'h0: next_s.coreSel = `SMCI_VCORE_1V5;
          2'h1: next_s.coreSel = `SMCI_VCORE_1V8;
          default: next_s.coreSel = `SMCI_VCORE_2V5;
        endcase
      end else begin
        next_s.latchWait = s.latchWait + 2'h1;
      end
    end

    // output stages
    if (s.cfgReg[`SMCI_CFG_PHASE_A_DC]) begin // [R11]
      // bridge mode keeps the idle low side on for recirculation
      next_s.stepA = s.motionReg[`SMCI_MOT_PHASE_A_DIR] ? {pwmA, 1'b1}
                                                         : {1'b1, pwmA};
    end else begin
      next_s.stepA = s.motionReg[`SMCI_MOT_PHASE_A_DIR] ? {pwmA, 1'b0}
                                                         : {1'b0, pwmA};
    end
    if (s.cfgReg[`SMCI_CFG_PHASE_B_LS]) begin // [R13]
      next_s.stepB = {s.motionReg[`SMCI_MOT_LS2_ON],
                      s.motionReg[`SMCI_MOT_LS1_ON]};
    end else begin // [R12]
      next_s.stepB = s.motionReg[`SMCI_MOT_PHASE_B_DIR] ? {pwmB, 1'b0}
                                                         : {1'b0, pwmB};
    end
    next_s.bridgeA = pwmBr & ~s.motionReg[`SMCI_MOT_BRIDGE_A_DIR]; // [R14]
    next_s.bridgeB = pwmBr & s.motionReg[`SMCI_MOT_BRIDGE_A_DIR];

    // bus: answer one edge after the request, complete on the next
    case (address)
      `SMCI_ADDR_STATUS: rdMux = {29'h0, s.irqStatus};
      `SMCI_ADDR_MASK: rdMux = {29'h0, s.irqMask};
      `SMCI_ADDR_MOTION: rdMux = {16'h0000, s.motionReg};
      `SMCI_ADDR_CONFIG: rdMux = {16'h0000, s.cfgReg};
      `SMCI_ADDR_INFO: rdMux = {27'h0, s.adcState, s.resetOutN, s.coreSel};
      default: rdMux = 32'h0000_0000;
    endcase
    next_s.waitreq = 1'b1;
    if ((read || write) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.readdata = read ? rdMux : 32'h0000_0000;
    end
    if (write && !s.waitreq) begin
      if (address == `SMCI_ADDR_STATUS) begin
        clr = writedata[2:0];
      end
      if (address == `SMCI_ADDR_MASK) begin
        next_s.irqMask = writedata[2:0];
      end
    end

    // sticky events; a new event beats a clear in the same cycle
    next_s.faultLast = faultNow;
    next_s.irqStatus = (s.irqStatus & ~clr) |
                       {faultNow & ~s.faultLast, adcDone, frameLoad};
    next_s.irq = |(next_s.irqStatus & next_s.irqMask);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.misoOeN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign readdata = s.readdata;
  assign waitrequest = s.waitreq;
  assign irq = s.irq;
  assign miso = s.miso;
  assign misoOeN = s.misoOeN;
  assign adcSampleHold = s.adcHold;
  assign stepPhaseAOutput = s.stepA;
  assign stepPhaseBOutput = s.stepB;
  assign bridgeAOutputA = s.bridgeA;
  assign bridgeAOutputB = s.bridgeB;
  assign coreVoltageSetting = s.coreSel;
  assign resetOutN = s.resetOutN;

  // ****************************************************
  // checks
  // ****************************************************
  logic [15:0] frameWordChk;
  assign frameWordChk = {s.inShift[14:0], link.mosi};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_last_edge;
    link.sclkRise && !link.ceN && (s.bitCnt == `SMCI_LAST_BIT);
  endsequence

  property p_motion_load;
    s_last_edge ##0 !link.mosi |=>
      (s.motionReg == $past(frameWordChk)) && s.irqStatus[0];
  endproperty
  a_motion_load: assert property (p_motion_load) // [R15]
    else $error("motion register not loaded on 16th edge");

  property p_cfg_load;
    s_last_edge ##0 link.mosi |=> s.cfgReg == $past(frameWordChk);
  endproperty
  a_cfg_load: assert property (p_cfg_load) // [R16]
    else $error("config register not loaded on 16th edge");

  property p_preload;
    link.sclkRise && link.ceN |=>
      s.outShift == $past(s.motionReg[15] ? statusWord : normalWord);
  endproperty
  a_preload: assert property (p_preload) // [R17]
    else $error("output word not preloaded while enable high");

  property p_shift_out;
    link.sclkRise && !link.ceN |=> s.miso == $past(s.outShift[14]);
  endproperty
  a_shift_out: assert property (p_shift_out) // [R3]
    else $error("data out did not advance one bit");

  property p_acq_end;
    (s.adcState == smci_pkg::ADC_ACQ) && link.sclkRise &&
    (s.adcCnt == acqLen - 7'h01) |=>
      (s.adcState == smci_pkg::ADC_CONV) && !s.adcHold;
  endproperty
  a_acq_end: assert property (p_acq_end) // [R5]
    else $error("acquisition length wrong");

  property p_conv_end;
    (s.adcState == smci_pkg::ADC_CONV) && link.sclkRise &&
    (s.adcCnt == convLen - 7'h01) |=>
      (s.adcState == smci_pkg::ADC_IDLE) && (s.adcWord == $past(s.adcRaw));
  endproperty
  a_conv_end: assert property (p_conv_end) // [R6]
    else $error("conversion end or result capture wrong");

  property p_core_stable;
    s.coreLatched |=> $stable(s.coreSel) && s.coreLatched;
  endproperty
  a_core_stable: assert property (p_core_stable) // [R9]
    else $error("core voltage setting changed after latch");

  property p_reset_timer;
    s.pinSync[7] && link.sclkRise && !s.resetOutN &&
    (s.rstCnt == `SMCI_RST_LAST) |=> s.resetOutN;
  endproperty
  a_reset_timer: assert property (p_reset_timer) // [R2]
    else $error("reset timer did not release at count end");

  property p_bridge;
    1'b1 |=> s.bridgeA == ($past(s.pinSync[2]) &
                           ~$past(s.motionReg[`SMCI_MOT_BRIDGE_A_DIR]));
  endproperty
  a_bridge: assert property (p_bridge) // [R14]
    else $error("bridge A output does not follow its pwm");

endmodule : smci_core

`default_nettype wire

// ==== verification/smci_host_model.sv ====
/*
  Host side of the serial link: free-running clock and a frame task.
  Assumes the device samples its pins on rising serial clock edges.
*/
`timescale 1ns/1ps
`default_nettype none

module smci_host_model (
  // serial pins
  output logic sclk,
  output logic ceN,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    ceN = 1'b1;
    mosi = 1'b0;
    forever #80 sclk = ~sclk;
  end

  // miso read at the falling edge before each rise, well after it settles
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      @(negedge sclk);
      rx[i] = miso;
      ceN <= 1'b0;
      mosi <= tx[i];
    end
    @(negedge sclk);
    ceN <= 1'b1;
    mosi <= 1'b0;
  endtask : frame
endmodule : smci_host_model

`default_nettype wire

// ==== verification/tb.sv ====
/*
  Self-checking bench of the serial motor control core.
  Assumes a host model on the serial pins and an Avalon master here.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic core_clk, rst, read, write, waitrequest, irq, miso, misoOeN;
  logic [2:0] address;
  logic [31:0] writedata, readdata, q;
  logic pwmA, pwmB, pwmBr, encA, encB, uv, ot, pg, sh, rstOutN, brA, brB;
  logic [1:0] vsel, vset, stA, stB;
  logic [11:0] adc;
  logic [15:0] rx;
  logic sclk, ceN, mosi;
  int errCount = 0;
  int totalChecks = 0;
  int cycles = 0;

  smci_core dut (.core_clk(core_clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .sclk(sclk), .ceN(ceN), .mosi(mosi), .miso(miso), .misoOeN(misoOeN),
    .phaseAPwmInput(pwmA), .phaseBPwmInput(pwmB), .bridgeAPwmInput(pwmBr),
    .encoderA(encA), .encoderB(encB), .underVoltage(uv), .overTemp(ot),
    .powerGood(pg), .coreVoltageSelectPin(vsel), .adcResult(adc),
    .adcSampleHold(sh), .stepPhaseAOutput(stA), .stepPhaseBOutput(stB),
    .bridgeAOutputA(brA), .bridgeAOutputB(brB),
    .coreVoltageSetting(vset), .resetOutN(rstOutN));

  smci_host_model host (.sclk(sclk), .ceN(ceN), .mosi(mosi), .miso(miso));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      conclude();
    end
  end

  task conclude;
    if (errCount == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] got, exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    write <= w;
    read <= ~w;
    address <= a;
    writedata <= d;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_c

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic test_reset;
    wait_c(10);
    chk("misoOeN", misoOeN, 32'h0);
    chk("vcore", vset, 32'h1);
    vsel <= 2'h2;
    repeat (120) @(posedge sclk);
    chk("vcore held", vset, 32'h1);
    chk("rst early", rstOutN, 32'h0);
    repeat (12) @(posedge sclk);
    wait_c(8);
    chk("rst done", rstOutN, 32'h1);
  endtask : test_reset

  task automatic test_irq;
    host.frame(16'h0A01, rx);
    wait_c(8);
    bus(1'b1, 3'h3, 32'h0);
    bus(1'b0, 3'h3, 32'h0);
    chk("config", q, 32'h0A01);
    bus(1'b0, 3'h2, 32'h0);
    chk("motion", q, 32'h0);
    chk("irq masked", irq, 32'h0);
    ot <= 1'b1;
    wait_c(10);
    bus(1'b0, 3'h0, 32'h0);
    chk("status", q, 32'h5);
    bus(1'b1, 3'h1, 32'h5);
    wait_c(2);
    chk("irq", irq, 32'h1);
    bus(1'b1, 3'h0, 32'h7);
    wait_c(2);
    chk("irq clear", irq, 32'h0);
    bus(1'b0, 3'h0, 32'h0);
    chk("status clear", q, 32'h0);
    bus(1'b1, 3'h7, 32'hFFFF);
    bus(1'b0, 3'h7, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask : test_irq

  task automatic test_adc;
    host.frame(16'h4400, rx);
    chk("hold", sh, 32'h1);
    wait_c(1);
    pwmA <= 1'b1;
    pwmB <= 1'b1;
    wait_c(10);
    chk("phase a", stA, 32'h2);
    chk("phase b", stB, 32'h1);
    bus(1'b0, 3'h2, 32'h0);
    chk("motion", q, 32'h4400);
    repeat (17) @(posedge sclk);
    wait_c(8);
    chk("hold end", sh, 32'h0);
    repeat (42) @(posedge sclk);
    wait_c(8);
    bus(1'b0, 3'h0, 32'h0);
    chk("adc busy", q[1], 32'h0);
    repeat (6) @(posedge sclk);
    wait_c(8);
    bus(1'b0, 3'h0, 32'h0);
    chk("adc done", q[1], 32'h1);
    host.frame(16'h0000, rx);
    chk("result", rx, {20'h0, adc});
    wait_c(10);
    chk("phase a dir", stA, 32'h1);
  endtask : test_adc

  // dc, lowside, slow converter and long filter modes with status report
  task automatic test_modes;
    host.frame(16'hF001, rx);
    host.frame(16'hC880, rx);
    wait_c(1);
    pwmBr <= 1'b1;
    encA <= 1'b1;
    // preload at the 6th edge must still show the old filtered level
    repeat (6) @(posedge sclk);
    host.frame(16'hC880, rx);
    chk("enc long", rx, 32'h7001);
    chk("slow hold", sh, 32'h1);
    chk("dc mode", stA, 32'h3);
    chk("lowside", stB, 32'h2);
    chk("bridge a", brA, 32'h0);
    chk("bridge b", brB, 32'h1);
    bus(1'b0, 3'h4, 32'h0);
    chk("info", q, 32'hD);
    host.frame(16'hC880, rx);
    chk("enc set", rx, 32'h7801);
    chk("slow end", sh, 32'h0);
  endtask : test_modes

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 3'h0;
    writedata = 32'h0;
    {pwmA, pwmB, pwmBr, encA, encB, uv, ot} = 7'h0;
    pg = 1'b1;
    vsel = 2'h1;
    adc = 12'hA5C;
    repeat (5) @(posedge core_clk);
    chk("wait rst", waitrequest, 32'h1);
    chk("oe rst", misoOeN, 32'h1);
    rst <= 1'b0;
    test_reset();
    test_irq();
    test_adc();
    test_modes();
    conclude();
  end
endmodule : tb

`default_nettype wire
